// ==== fsl_map.svh ====
// Command codes, offsets, reset values and timing counts of the flash sequencer
`ifndef FSL_MAP_SVH
`define FSL_MAP_SVH
// Functional notes
// RL1 - Erase suspend may target any address of the block; erase halts at next checkpoint.
// RL2 - During erase suspend, programs and reads go to any block but the suspended one.
// RL3 - A suspended erase shows ready and erase-suspended status bits together.
// RL4 - No new erase while one is suspended; two nesting levels: erase, then program.
// RL5 - A suspended erase cannot resume while its nested program still runs.
// RL6 - Erase suspend accepts reads, program, suspend, resume, clear and lock commands.
// RL7 - Resume may go to any address and continues the latest suspended operation.
// RL8 - Nested case: first resume continues the program, a second resume the erase.
// RL9 - Reset locks every block; program or erase on a locked block aborts with error.
// RL10 - Lock takes effect at once, unlock clears it, reset relocks every block.
// RL11 - Lock-down sets lock-down bit and locks; only reset clears lock-down.
// RL12 - Write-protect asserted holds lock-down blocks locked; released, software may unlock.
// RL13 - Lock commands in erase suspend act at once; the resumed erase still finishes.
// RL14 - Lock setup followed by a foreign command sets status bits 4 and 5.
// RL15 - No lock, unlock or lock-down while a program is suspended.
// RL16 - Seventeen 128-bit protection words; low half of word zero is factory data.
// RL17 - Identifier mode returns protection contents one 16-bit word per read.
// RL18 - Protection program writes one word; outside the space it sets status bit 4.
// RL19 - Lock register zero: bit 0 guards the factory half, bit 1 the user half.
// RL20 - Lock register one bit n-1 guards protection word n.
// RL21 - Protection program to a locked segment keeps data, sets status bits 5 and 4.
// RL22 - Array program and erase are inhibited while the enable supply is below lockout; the code checks the supply only at start, not on resume.
// RL23 - Ready bit is 0 while program or erase runs, 1 when ready.
// RL24 - Error bits are only set by hardware; clear-status or reset clears them.
// RL25 - A command invalid in the current suspend state is a command sequence error.

`define FSL_CMD_READ_ARRAY  8'hff
`define FSL_CMD_READ_STATUS 8'h70
`define FSL_CMD_READ_ID     8'h90
`define FSL_CMD_QUERY       8'h98
`define FSL_CMD_PROG        8'h40
`define FSL_CMD_PROG_ALT    8'h10
`define FSL_CMD_ERASE_SETUP 8'h20
`define FSL_CMD_CONFIRM     8'hd0
`define FSL_CMD_SUSPEND     8'hb0
`define FSL_CMD_CLEAR       8'h50
`define FSL_CMD_LOCK_SETUP  8'h60
`define FSL_CMD_LOCK        8'h01
`define FSL_CMD_LOCKDOWN    8'h2f
`define FSL_CMD_OTP_PROG    8'hc0

`define FSL_BLK_WORD_BITS   16
`define FSL_ID_MANUF_OFF    16'h0000
`define FSL_ID_DEVICE_OFF   16'h0001
`define FSL_ID_BLKLOCK_OFF  16'h0002
`define FSL_OTP_BASE        16'h0080
`define FSL_OTP_LAST        16'h0109
`define FSL_OTP_WORDS       138
`define FSL_OTP_LOCK1_IDX   8'h09
`define FSL_OTP_PR1_IDX     8'h0a
`define FSL_OTP_FACT_LAST   8'h04
`define FSL_OTP_USER0_LAST  8'h08
`define FSL_LOCK0_RST       16'hfffe
`define FSL_LOCK1_RST       16'hffff
`define FSL_OTP_ERASED      16'hffff
`define FSL_LOCK0_USER_MASK 16'h0002

// Error vector order: status bits 5, 4, 3, 1
`define FSL_ERR_SEQ         4'b1100
`define FSL_ERR_PLOCK       4'b0101
`define FSL_ERR_PSUP        4'b0110
`define FSL_ERR_ELOCK       4'b1001
`define FSL_ERR_ESUP        4'b1010
`define FSL_ERR_RANGE       4'b0100

`define FSL_CLK_MHZ         100
`define FSL_ERASE_TIME_US   10
`define FSL_PROG_TIME_US    1
`define FSL_ERASE_CYC       (`FSL_ERASE_TIME_US * `FSL_CLK_MHZ)
`define FSL_PROG_CYC        (`FSL_PROG_TIME_US * `FSL_CLK_MHZ)
`define FSL_CHK_W           4
`endif

// ==== fsl_pkg.sv ====
// Types shared by the flash sequencer modules
`default_nettype none
package fsl_pkg;
  typedef enum logic [2:0] {
    OP_IDLE, OP_ERASE, OP_ESUSP, OP_PROG, OP_PSUSP, OP_ES_PROG, OP_ES_PSUSP
  } fsl_op_t;
  typedef enum logic [2:0] {SQ_NONE, SQ_PROG, SQ_ERASE, SQ_LOCK, SQ_OTP} fsl_seq_t;
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} fsl_rmode_t;
  typedef struct packed {
    logic rdy;
    logic esusp;
    logic ee;
    logic pe;
    logic ve;
    logic psusp;
    logic lk_err;
    logic befp;
  } fsl_status_t;
  typedef struct packed {
    logic lock;
    logic unlock;
    logic lockdown;
  } fsl_lock_op_t;
endpackage
`default_nettype wire

// ==== fsl_block_lock.sv ====
// Lock and lock-down state of one array block
`timescale 1ns/1ps
`default_nettype none
module fsl_block_lock (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 sel,
  input  wire fsl_pkg::fsl_lock_op_t op,
  input  wire logic                 wp_act,
  output logic                      locked,
  output logic                      lockdown
);
  logic locked_q;
  logic ld_q;
  logic hold;

  assign hold = ld_q & wp_act;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      locked_q <= 1'b1;
      ld_q     <= 1'b0;
    end else begin
      if (sel && op.lockdown) ld_q <= 1'b1;  // see RL11
      // Write-protect hold beats a same-cycle unlock
      if (hold || (sel && (op.lock || op.lockdown))) locked_q <= 1'b1;  // see RL12
      else if (sel && op.unlock) locked_q <= 1'b0;  // see RL10
    end
  end

  assign locked   = locked_q;
  assign lockdown = ld_q;
endmodule
`default_nettype wire

// ==== fsl_otp_store.sv ====
// One-time-programmable protection words and their lock registers
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"
module fsl_otp_store #(
  parameter int          WORDS = `FSL_OTP_WORDS,
  parameter logic [63:0] UID   = 64'h0123_4567_89ab_cdef  // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [7:0]  rd_idx,
  output logic      [15:0] rd_data,
  output logic      [15:0] lock0,
  output logic      [15:0] lock1
);
  logic [15:0] mem_q [WORDS];

  // Reset stands in for the power-on load of the nonvolatile contents
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < WORDS; i++) mem_q[i] <= `FSL_OTP_ERASED;
      mem_q[0] <= `FSL_LOCK0_RST;
      mem_q[`FSL_OTP_LOCK1_IDX] <= `FSL_LOCK1_RST;
      for (int i = 0; i < 4; i++) mem_q[i+1] <= UID[16*i +: 16];  // see RL16
    end else if (wr_en) begin
      // Programming only clears bits, one word per command
      mem_q[wr_idx] <= mem_q[wr_idx] & wr_data;  // see RL18
    end
  end

  assign rd_data = (rd_idx < 8'(WORDS)) ? mem_q[rd_idx] : 16'h0000;  // see RL17
  assign lock0   = mem_q[0];
  assign lock1   = mem_q[`FSL_OTP_LOCK1_IDX];
endmodule
`default_nettype wire

// ==== fsl_top.sv ====
// Flash command sequencer: suspend/resume, block locking and protection words
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"
module fsl_top #(
  parameter int          BLK_AW    = 7,
  parameter int          ERASE_CYC = `FSL_ERASE_CYC,
  parameter int          PROG_CYC  = `FSL_PROG_CYC,
  parameter int          CHK_W     = `FSL_CHK_W,
  parameter logic [15:0] MANUF_ID  = 16'h00a5,  // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5a01,  // Arbitrary value
  parameter logic [63:0] UID       = 64'h0123_4567_89ab_cdef  // Arbitrary value
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   cmd_we,
  input  wire logic [BLK_AW+15:0]     cmd_addr,
  input  wire logic [15:0]            cmd_data,
  input  wire logic [BLK_AW+15:0]     rd_addr,
  output logic      [15:0]            rd_data,
  output var fsl_pkg::fsl_rmode_t     read_mode,
  output var fsl_pkg::fsl_status_t    status,
  input  wire logic                   wp_n,
  input  wire logic                   program_enable_supply_ok
);
  localparam int AW   = BLK_AW + 16;
  localparam int NBLK = 1 << BLK_AW;
  localparam int EW   = $clog2(ERASE_CYC + 1);
  localparam int PW   = $clog2(PROG_CYC + 1);

  fsl_pkg::fsl_op_t     op_q, op_d;
  fsl_pkg::fsl_seq_t    seq_q, seq_d;
  fsl_pkg::fsl_rmode_t  rmode_q, rmode_d;
  fsl_pkg::fsl_status_t status_w, status_q;
  fsl_pkg::fsl_lock_op_t lk_op;
  logic [3:0]        err_q, err_d, err_set;
  logic              err_clr;
  logic [EW-1:0]     ecnt_q, ecnt_d;
  logic [PW-1:0]     pcnt_q, pcnt_d;
  logic              esreq_q, esreq_d;
  logic [BLK_AW-1:0] eblk_q, eblk_d;
  logic [15:0]       rd_q, rd_w, id_w;
  logic              wp_s1_q, wp_s2_q, pen_s1_q, pen_s2_q;
  logic              wp_act, pen_ok;
  logic [NBLK-1:0]   blk_locked, blk_ld;

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
      pen_s1_q <= 1'b0;
      pen_s2_q <= 1'b0;
    end else begin
      wp_s1_q  <= wp_n;
      wp_s2_q  <= wp_s1_q;
      pen_s1_q <= program_enable_supply_ok;
      pen_s2_q <= pen_s1_q;
    end
  end
  assign wp_act = ~wp_s2_q;
  assign pen_ok = pen_s2_q;

  // Command decode
  logic [7:0]        cmd;
  logic [BLK_AW-1:0] cblk, rblk;
  logic [15:0]       coff, roff;
  logic              busy, in_ps, in_es, sel_locked, resume_go, lk_bad;
  assign cmd        = cmd_data[7:0];
  assign cblk       = cmd_addr[AW-1:`FSL_BLK_WORD_BITS];
  assign rblk       = rd_addr[AW-1:`FSL_BLK_WORD_BITS];
  assign coff       = cmd_addr[15:0];
  assign roff       = rd_addr[15:0];
  assign busy       = (op_q == fsl_pkg::OP_ERASE) || (op_q == fsl_pkg::OP_PROG)
                      || (op_q == fsl_pkg::OP_ES_PROG);
  assign in_ps      = (op_q == fsl_pkg::OP_PSUSP) || (op_q == fsl_pkg::OP_ES_PSUSP);
  assign in_es      = (op_q == fsl_pkg::OP_ESUSP) || (op_q == fsl_pkg::OP_ES_PROG)
                      || (op_q == fsl_pkg::OP_ES_PSUSP);
  assign sel_locked = blk_locked[cblk];
  assign resume_go  = cmd_we && !busy && (seq_q == fsl_pkg::SQ_NONE)
                      && (cmd == `FSL_CMD_CONFIRM)
                      && ((op_q == fsl_pkg::OP_ESUSP) || in_ps);
  assign lk_bad     = (cmd != `FSL_CMD_LOCK) && (cmd != `FSL_CMD_CONFIRM)
                      && (cmd != `FSL_CMD_LOCKDOWN);

  // Protection word addressing
  logic        otp_in, otp_lk, otp_we;
  logic [7:0]  otp_widx, pr_off, otp_ridx;
  logic [15:0] otp_wdata, otp_rd, lock0, lock1;
  assign otp_in    = (coff >= `FSL_OTP_BASE) && (coff <= `FSL_OTP_LAST);
  assign otp_widx  = 8'(coff - `FSL_OTP_BASE);
  assign otp_ridx  = 8'(roff - `FSL_OTP_BASE);
  assign pr_off    = otp_widx - `FSL_OTP_PR1_IDX;
  assign otp_lk    = (otp_widx == 8'h00 || otp_widx == `FSL_OTP_LOCK1_IDX) ? 1'b0 :
                     (otp_widx <= `FSL_OTP_FACT_LAST)  ? ~lock0[0] :  // see RL19
                     (otp_widx <= `FSL_OTP_USER0_LAST) ? ~lock0[1] :
                     ~lock1[pr_off[6:3]];  // see RL20
  // Only bit 1 of lock register zero belongs to the user
  assign otp_wdata = (otp_widx == 8'h00) ? (cmd_data | ~`FSL_LOCK0_USER_MASK) : cmd_data;

  fsl_otp_store #(
    .WORDS (`FSL_OTP_WORDS),
    .UID   (UID)
  ) u_otp (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (otp_we),
    .wr_idx   (otp_widx),
    .wr_data  (otp_wdata),
    .rd_idx   (otp_ridx),
    .rd_data  (otp_rd),
    .lock0    (lock0),
    .lock1    (lock1)
  );

  for (genvar b = 0; b < NBLK; b++) begin : g_blk
    fsl_block_lock u_lock (
      .core_clk (core_clk),
      .rst      (rst),
      .sel      (cblk == BLK_AW'(b)),
      .op       (lk_op),
      .wp_act   (wp_act),
      .locked   (blk_locked[b]),
      .lockdown (blk_ld[b])
    );
  end

  // Write state machine and command sequencing
  always_comb begin
    op_d    = op_q;
    seq_d   = seq_q;
    rmode_d = rmode_q;
    err_set = 4'h0;
    err_clr = 1'b0;
    lk_op   = '0;
    otp_we  = 1'b0;
    eblk_d  = eblk_q;
    esreq_d = esreq_q;
    ecnt_d  = ecnt_q;
    pcnt_d  = pcnt_q;
    case (op_q)
      fsl_pkg::OP_ERASE: begin
        if (ecnt_q == '0) begin
          op_d    = fsl_pkg::OP_IDLE;
          esreq_d = 1'b0;
        end else if (esreq_q && (ecnt_q[CHK_W-1:0] == '0)) begin
          op_d    = fsl_pkg::OP_ESUSP;  // see RL1
          esreq_d = 1'b0;
        end else begin
          ecnt_d = ecnt_q - 1'b1;
        end
      end
      fsl_pkg::OP_PROG, fsl_pkg::OP_ES_PROG: begin
        if (pcnt_q == '0) begin
          // Nested program done: back to the suspended erase, not into it
          op_d = (op_q == fsl_pkg::OP_PROG) ? fsl_pkg::OP_IDLE : fsl_pkg::OP_ESUSP;  // see RL5
        end else begin
          pcnt_d = pcnt_q - 1'b1;
        end
      end
      default: ;
    endcase
    if (cmd_we && busy) begin
      // While busy only suspend and status reads are heeded
      if (cmd == `FSL_CMD_READ_STATUS || cmd == `FSL_CMD_SUSPEND) rmode_d = fsl_pkg::RM_STATUS;
      if (cmd == `FSL_CMD_SUSPEND) begin
        if (op_d == fsl_pkg::OP_ERASE) esreq_d = 1'b1;  // see RL1
        else if (op_d == fsl_pkg::OP_PROG) op_d = fsl_pkg::OP_PSUSP;
        else if (op_d == fsl_pkg::OP_ES_PROG) op_d = fsl_pkg::OP_ES_PSUSP;  // see RL4
      end
    end else if (cmd_we && seq_q == fsl_pkg::SQ_NONE) begin
      case (cmd)  // see RL6
        `FSL_CMD_READ_ARRAY:  rmode_d = fsl_pkg::RM_ARRAY;
        `FSL_CMD_READ_STATUS: rmode_d = fsl_pkg::RM_STATUS;
        `FSL_CMD_READ_ID:     rmode_d = fsl_pkg::RM_ID;
        `FSL_CMD_QUERY:       rmode_d = fsl_pkg::RM_QUERY;
        `FSL_CMD_CLEAR:       err_clr = 1'b1;  // see RL24
        `FSL_CMD_SUSPEND:     rmode_d = fsl_pkg::RM_STATUS;
        `FSL_CMD_PROG, `FSL_CMD_PROG_ALT: begin
          if (in_ps) err_set = `FSL_ERR_SEQ;  // see RL25
          else seq_d = fsl_pkg::SQ_PROG;
        end
        `FSL_CMD_ERASE_SETUP: begin
          if (op_q == fsl_pkg::OP_IDLE) seq_d = fsl_pkg::SQ_ERASE;
          else err_set = `FSL_ERR_SEQ;  // see RL4
        end
        `FSL_CMD_LOCK_SETUP: begin
          if (in_ps) err_set = `FSL_ERR_SEQ;  // see RL15
          else seq_d = fsl_pkg::SQ_LOCK;
        end
        `FSL_CMD_OTP_PROG: begin
          if (op_q == fsl_pkg::OP_IDLE) seq_d = fsl_pkg::SQ_OTP;
          else err_set = `FSL_ERR_SEQ;  // see RL25
        end
        `FSL_CMD_CONFIRM: begin
          rmode_d = fsl_pkg::RM_STATUS;
          case (op_q)  // see RL7
            fsl_pkg::OP_ESUSP:    op_d = fsl_pkg::OP_ERASE;
            fsl_pkg::OP_PSUSP:    op_d = fsl_pkg::OP_PROG;
            fsl_pkg::OP_ES_PSUSP: op_d = fsl_pkg::OP_ES_PROG;  // see RL8
            default: ;
          endcase
        end
        default: err_set = `FSL_ERR_SEQ;
      endcase
    end else if (cmd_we) begin
      seq_d   = fsl_pkg::SQ_NONE;
      rmode_d = fsl_pkg::RM_STATUS;
      case (seq_q)
        fsl_pkg::SQ_PROG: begin
          if (op_q == fsl_pkg::OP_ESUSP && cblk == eblk_q) err_set = `FSL_ERR_SEQ;  // see RL2
          else if (sel_locked) err_set = `FSL_ERR_PLOCK;  // see RL9
          else if (!pen_ok) err_set = `FSL_ERR_PSUP;  // see RL22
          else begin
            pcnt_d = PW'(PROG_CYC - 1);
            op_d   = (op_q == fsl_pkg::OP_ESUSP) ? fsl_pkg::OP_ES_PROG : fsl_pkg::OP_PROG;
          end
        end
        fsl_pkg::SQ_ERASE: begin
          if (cmd != `FSL_CMD_CONFIRM) err_set = `FSL_ERR_SEQ;
          else if (sel_locked) err_set = `FSL_ERR_ELOCK;  // see RL9
          else if (!pen_ok) err_set = `FSL_ERR_ESUP;  // see RL22
          else begin
            op_d   = fsl_pkg::OP_ERASE;
            eblk_d = cblk;
            ecnt_d = EW'(ERASE_CYC - 1);
          end
        end
        fsl_pkg::SQ_LOCK: begin
          // Applies at once, also to a block whose erase is suspended
          case (cmd)  // see RL13
            `FSL_CMD_LOCK:     lk_op.lock = 1'b1;  // see RL10
            `FSL_CMD_CONFIRM:  lk_op.unlock = 1'b1;
            `FSL_CMD_LOCKDOWN: lk_op.lockdown = 1'b1;  // see RL11
            default:           err_set = `FSL_ERR_SEQ;  // see RL14
          endcase
        end
        fsl_pkg::SQ_OTP: begin
          if (!otp_in) err_set = `FSL_ERR_RANGE;  // see RL18
          else if (otp_lk) err_set = `FSL_ERR_SEQ;  // see RL21
          else otp_we = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // A hardware set in the clearing cycle survives the clear
  assign err_d = (err_q & ~{4{err_clr}}) | err_set;  // see RL24

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_q    <= fsl_pkg::OP_IDLE;
      seq_q   <= fsl_pkg::SQ_NONE;
      rmode_q <= fsl_pkg::RM_ARRAY;
      err_q   <= 4'h0;
      ecnt_q  <= '0;
      pcnt_q  <= '0;
      esreq_q <= 1'b0;
      eblk_q  <= '0;
    end else begin
      op_q    <= op_d;
      seq_q   <= seq_d;
      rmode_q <= rmode_d;
      err_q   <= err_d;
      ecnt_q  <= ecnt_d;
      pcnt_q  <= pcnt_d;
      esreq_q <= esreq_d;
      eblk_q  <= eblk_d;
    end
  end

  // Status word and read data
  assign status_w.rdy   = ~busy;  // see RL23
  assign status_w.esusp = in_es;  // see RL3
  assign status_w.ee    = err_q[3];
  assign status_w.pe    = err_q[2];
  assign status_w.ve    = err_q[1];
  assign status_w.psusp = in_ps;
  assign status_w.lk_err = err_q[0];
  assign status_w.befp  = 1'b0;

  assign id_w = (roff == `FSL_ID_MANUF_OFF)   ? MANUF_ID :
                (roff == `FSL_ID_DEVICE_OFF)  ? DEVICE_ID :
                (roff == `FSL_ID_BLKLOCK_OFF) ? {14'h0000, blk_ld[rblk], blk_locked[rblk]} :
                ((roff >= `FSL_OTP_BASE) && (roff <= `FSL_OTP_LAST)) ? otp_rd :  // see RL17
                16'h0000;
  // Array and query data come from outside this block
  assign rd_w = (rmode_q == fsl_pkg::RM_STATUS) ? {8'h00, status_w} :
                (rmode_q == fsl_pkg::RM_ID)     ? id_w : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_q     <= 16'h0000;
      status_q <= '0;
    end else begin
      rd_q     <= rd_w;
      status_q <= status_w;
    end
  end

  assign rd_data   = rd_q;
  assign status    = status_q;
  assign read_mode = rmode_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_nested_resume;
    (op_q == fsl_pkg::OP_ES_PSUSP) && resume_go ##1 (op_q == fsl_pkg::OP_ES_PROG);
  endsequence

  chk_reset_locks_all: assert property ( // see RL9
    @(posedge core_clk) disable iff (1'b0)
    rst |=> (&blk_locked) && !(|blk_ld) && (err_q == 4'h0))
    else $error("blocks not all locked after reset");
  chk_suspend_halts: assert property ( // see RL1
    (op_q == fsl_pkg::OP_ERASE) && cmd_we && (cmd == `FSL_CMD_SUSPEND)
    |-> ##[1:17] (op_q != fsl_pkg::OP_ERASE))
    else $error("erase did not halt after suspend");
  chk_susp_flags: assert property ( // see RL3
    (op_q == fsl_pkg::OP_ESUSP) |=> status.rdy && status.esusp)
    else $error("suspended erase not shown in status");
  chk_no_nested_erase: assert property ( // see RL4
    (op_q == fsl_pkg::OP_ESUSP) && cmd_we && (seq_q == fsl_pkg::SQ_NONE)
    && (cmd == `FSL_CMD_ERASE_SETUP)
    |=> (op_q == fsl_pkg::OP_ESUSP) && (err_q[3:2] == 2'b11))
    else $error("erase setup accepted in erase suspend");
  chk_prog_other_blk: assert property ( // see RL2
    (op_q == fsl_pkg::OP_ESUSP) && cmd_we && (seq_q == fsl_pkg::SQ_PROG) && (cblk == eblk_q)
    |=> (op_q == fsl_pkg::OP_ESUSP))
    else $error("program started in suspended block");
  chk_resume_waits: assert property ( // see RL5
    (op_q == fsl_pkg::OP_ES_PROG) |=> (op_q != fsl_pkg::OP_ERASE))
    else $error("erase resumed under nested program");
  chk_nested_order: assert property ( // see RL8
    s_nested_resume |=> (op_q == fsl_pkg::OP_ES_PROG) || (op_q == fsl_pkg::OP_ES_PSUSP)
    || (op_q == fsl_pkg::OP_ESUSP))
    else $error("nested resume did not continue program");
  chk_resume_erase: assert property ( // see RL7
    (op_q == fsl_pkg::OP_ESUSP) && resume_go |=> (op_q == fsl_pkg::OP_ERASE))
    else $error("resume did not continue erase");
  chk_locked_abort: assert property ( // see RL9
    (seq_q == fsl_pkg::SQ_ERASE) && cmd_we && (cmd == `FSL_CMD_CONFIRM) && sel_locked
    |=> (op_q == $past(op_q)) && err_q[0] && err_q[3])
    else $error("erase on locked block not aborted");
  chk_lock_at_once: assert property ( // see RL10
    (seq_q == fsl_pkg::SQ_LOCK) && cmd_we && !busy && (cmd == `FSL_CMD_LOCK)
    |=> blk_locked[$past(cblk)])
    else $error("lock not applied next cycle");
  chk_wp_holds_lock: assert property ( // see RL12
    (seq_q == fsl_pkg::SQ_LOCK) && cmd_we && (cmd == `FSL_CMD_CONFIRM)
    && wp_act && blk_ld[cblk]
    |=> blk_locked[$past(cblk)])
    else $error("unlock took effect under write-protect");
  chk_lock_seq_err: assert property ( // see RL14
    (seq_q == fsl_pkg::SQ_LOCK) && cmd_we && lk_bad |=> (err_q[3:2] == 2'b11))
    else $error("bad lock sequence not flagged");
  chk_no_lock_psusp: assert property ( // see RL15
    in_ps && cmd_we && (seq_q == fsl_pkg::SQ_NONE) && (cmd == `FSL_CMD_LOCK_SETUP)
    |=> (seq_q == fsl_pkg::SQ_NONE) && (err_q[3:2] == 2'b11))
    else $error("lock setup accepted in program suspend");
  chk_otp_locked: assert property ( // see RL21
    (seq_q == fsl_pkg::SQ_OTP) && cmd_we && otp_in && otp_lk
    |=> (err_q[3:2] == 2'b11) && $stable(otp_rd))
    else $error("locked protection word not refused");
  chk_supply_inhibit: assert property ( // see RL22
    !pen_ok && cmd_we && ((seq_q == fsl_pkg::SQ_PROG) || (seq_q == fsl_pkg::SQ_ERASE))
    |=> !busy)
    else $error("array operation started below lockout");
  chk_clear_status: assert property ( // see RL24
    err_clr && (err_set == 4'h0) |=> (err_q == 4'h0))
    else $error("clear-status did not clear errors");
endmodule
`default_nettype wire

// ==== fsl_host_model.sv ====
// Host model that issues flash command bus writes
`timescale 1ns/1ps
`default_nettype none
module fsl_host_model (
  input  wire logic        core_clk,
  output logic             cmd_we,
  output logic [22:0]      cmd_addr,
  output logic [15:0]      cmd_data
);
  initial begin
    cmd_we = 1'b0;
    cmd_addr = 23'h0;
    cmd_data = 16'h0;
  end
  // One write cycle; suspend and resume may target any address
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    @(negedge core_clk);
    cmd_we = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    @(negedge core_clk);
    cmd_we = 1'b0;
    // Idle bus never repeats the last value
    cmd_addr = ~a;
    cmd_data = ~d;
  endtask
endmodule
`default_nettype wire

// ==== fsl_top_test.sv ====
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"
module fsl_top_test;
  logic core_clk, rst, cmd_we, wp_n, sup;
  logic [22:0] cmd_addr, rd_addr;
  logic [15:0] cmd_data, rd_data;
  fsl_pkg::fsl_rmode_t read_mode;
  fsl_pkg::fsl_status_t status;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  typedef struct packed {logic [22:0] a; logic [15:0] c1, c2; logic [7:0] st;} fsl_row_t;
  fsl_row_t rows [8] = '{
    {23'h010000, 16'h0020, 16'h00d0, 8'ha2},
    {23'h010005, 16'h0040, 16'h1234, 8'h92},
    {23'h010000, 16'h0060, 16'h00ff, 8'hb0},
    {23'h000200, 16'h00c0, 16'h0000, 8'h90},
    {23'h000081, 16'h00c0, 16'h0000, 8'hb0},
    {23'h00008a, 16'h00c0, 16'h00f0, 8'h80},
    {23'h000089, 16'h00c0, 16'hfffe, 8'h80},
    {23'h00008a, 16'h00c0, 16'h0000, 8'hb0}};
  localparam logic [22:0] B2 = 23'h020000;
  localparam logic [22:0] B3 = 23'h030000;
  fsl_top #(.ERASE_CYC(40), .PROG_CYC(4)) i_fsl_top (.core_clk(core_clk), .rst(rst),
    .cmd_we(cmd_we), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .read_mode(read_mode), .status(status), .wp_n(wp_n),
    .program_enable_supply_ok(sup));
  fsl_host_model i_fsl_host_model (.core_clk(core_clk), .cmd_we(cmd_we),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Long erase may still be running: poll ready with a bound
  task automatic idle();
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 100 && status.rdy !== 1'b1; i++) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [22:0] a, input logic [15:0] d);
    i_fsl_host_model.wr(a, d);
    idle();
  endtask
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    sup = 1'b1;
    rd_addr = 23'h0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("reset status", 16'h0080, {8'h0, status});
    chk("reset mode", 16'h0, {14'h0, read_mode});
    foreach (rows[i]) begin
      i_fsl_host_model.wr(rows[i].a, rows[i].c1);
      cmd(rows[i].a, rows[i].c2);
      chk("error status", {8'h0, rows[i].st}, {8'h0, status});
      cmd(23'h0, 16'h0050);
      chk("cleared status", 16'h0080, {8'h0, status});
    end
    rd_addr = 23'h00008a;
    cmd(23'h0, 16'h0090);
    chk("protection word", 16'h00f0, rd_data);
    rd_addr = 23'h010002;
    i_fsl_host_model.wr(23'h010000, 16'h0060);
    cmd(23'h010000, 16'h00d0);
    cmd(23'h0, 16'h0090);
    chk("unlocked", 16'h0000, rd_data);
    i_fsl_host_model.wr(23'h010000, 16'h0060);
    cmd(23'h010000, 16'h002f);
    cmd(23'h0, 16'h0090);
    chk("locked down", 16'h0003, rd_data);
    wp_n = 1'b0;
    i_fsl_host_model.wr(23'h010000, 16'h0060);
    cmd(23'h010000, 16'h00d0);
    cmd(23'h0, 16'h0090);
    chk("wp holds lock", 16'h0003, rd_data);
    wp_n = 1'b1;
    i_fsl_host_model.wr(23'h010000, 16'h0060);
    cmd(23'h010000, 16'h00d0);
    cmd(23'h0, 16'h0090);
    chk("wp released unlock", 16'h0002, rd_data);
    i_fsl_host_model.wr(B2, 16'h0060);
    cmd(B2, 16'h00d0);
    i_fsl_host_model.wr(B2, 16'h0020);
    i_fsl_host_model.wr(B2, 16'h00d0);
    cmd(B2 + 23'h5, 16'h00b0);
    chk("suspended", 16'h00c0, {8'h0, status});
    i_fsl_host_model.wr(B2, 16'h0040);
    cmd(B2, 16'h1111);
    chk("prog suspended blk", 16'h00f0, {8'h0, status});
    cmd(23'h0, 16'h0050);
    i_fsl_host_model.wr(B2, 16'h0020);
    cmd(B2, 16'h00ff);
    chk("erase in suspend", 16'h00f0, {8'h0, status});
    cmd(23'h0, 16'h0050);
    chk("clear in suspend", 16'h00c0, {8'h0, status});
    i_fsl_host_model.wr(B2, 16'h0060);
    cmd(B2, 16'h0001);
    i_fsl_host_model.wr(B3, 16'h0060);
    cmd(B3, 16'h00d0);
    i_fsl_host_model.wr(B3, 16'h0040);
    i_fsl_host_model.wr(B3, 16'h1234);
    cmd(B3, 16'h00b0);
    chk("program suspended", 16'h00c4, {8'h0, status});
    cmd(B3, 16'h0060);
    chk("lock in prog suspend", 16'h00f4, {8'h0, status});
    cmd(23'h0, 16'h0050);
    cmd(23'h3, 16'h00d0);
    chk("nested prog done", 16'h00c0, {8'h0, status});
    cmd(23'h7, 16'h00d0);
    chk("resumed done", 16'h0080, {8'h0, status});
    sup = 1'b0;
    i_fsl_host_model.wr(B3, 16'h0020);
    cmd(B3, 16'h00d0);
    chk("supply low", 16'h00a8, {8'h0, status});
    complete_run();
  end
endmodule
`default_nettype wire
